// ===== logic/rbsx_bcd_sub.sv
// rbsx_bcd_sub: packed bcd byte subtraction with extend, combinational.
// assumes operands are valid bcd digits; other codes give a defined but meaningless result.
`timescale 1ns/100ps
module rbsx_bcd_sub (
  input wire logic [7:0] dst,
  input wire logic [7:0] src,
  input wire logic x_in,
  output logic [7:0] result,
  output logic borrow
);
  // per-digit subtract, a negative digit is pulled back by six and borrows
  always_comb begin
    logic [4:0] lo;
    logic [4:0] hi;
    logic lo_b;
    hi = 5'h00;
    lo_b = 1'b0;
    lo = {1'b0, dst[3:0]} - {1'b0, src[3:0]} - {4'h0, x_in};
    lo_b = lo[4];
    if (lo_b) begin
      lo = lo - 5'h06;
    end
    hi = {1'b0, dst[7:4]} - {1'b0, src[7:4]} - {4'h0, lo_b};
    borrow = hi[4];
    if (hi[4]) begin
      hi = hi - 5'h06;
    end
    result = {hi[3:0], lo[3:0]};
  end
endmodule : rbsx_bcd_sub

// ===== logic/rbsx_exec.sv
// rbsx_exec: decode and sequencing of the four returns, decimal subtract and memory rotate.
// assumes a datapath that applies the write strobes at the next edge, a register file
// that answers an index in the following cycle and a memory port answering with mem_ack.
`timescale 1ns/100ps
module rbsx_exec
  import rbsx_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic insn_valid,
  input wire logic [15:0] insn_word,
  input wire logic [15:0] ext_word,
  input wire logic [15:0] status_in,
  input wire logic [31:0] sp_in,
  input wire logic [31:0] rf_rd_x,
  input wire logic [31:0] rf_rd_y,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic busy,
  output logic done,
  output logic [3:0] rf_idx_x,
  output logic [3:0] rf_idx_y,
  output logic rf_we,
  output logic [3:0] rf_wr_idx,
  output logic [31:0] rf_wr_data,
  output logic mem_req,
  output logic mem_we,
  output logic [1:0] mem_size,
  output logic [31:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic pc_we,
  output logic [31:0] pc_out,
  output logic sp_we,
  output logic [31:0] sp_out,
  output logic status_we,
  output logic [15:0] status_out,
  output logic cond_we,
  output logic [4:0] cond_out,
  output logic stack_switch,
  output logic priv_violation,
  output logic format_error,
  output logic illegal_ea,
  output logic resume_frame,
  output logic rot_start,
  output logic rot_left,
  output logic [2:0] rot_ea_mode,
  output logic [2:0] rot_ea_reg
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_REG, ST_MEM, ST_NEXT, ST_CALC, ST_SWITCH, ST_RESTART
  } rbsx_state_e;

  rbsx_state_e state;
  rbsx_op_e op;
  logic [1:0] step;
  logic [31:0] base;
  logic [15:0] disp;
  logic [15:0] status_tmp;
  logic [31:0] pc_tmp;
  logic [31:0] rd_data;
  logic [31:0] dst_full;
  logic [31:0] ay_addr;
  logic [7:0] src_b;
  logic [7:0] dst_b;
  logic [2:0] reg_y;
  logic [7:0] bcd_res;
  logic bcd_borrow;
  logic accept;
  logic rot_hit;
  logic rot_legal;
  logic bcd_hit;
  logic [2:0] ea_mode;
  logic [2:0] ea_reg;
  logic [3:0] fmt;
  logic [5:0] frame_words;
  logic [31:0] frame_bytes;
  logic [31:0] disp_sext;
  logic [31:0] ax_dec;
  logic [31:0] ay_dec;

  // decode of the incoming opcode word
  assign accept = insn_valid && (state == ST_IDLE);
  assign ea_mode = insn_word[EA_MODE_LSB +: 3];
  assign ea_reg = insn_word[EA_REG_LSB +: 3];
  assign rot_hit = (insn_word & ROT_MEM_MASK) == ROT_MEM_CODE;
  assign bcd_hit = (insn_word & BCD_SUB_MASK) == BCD_SUB_CODE;
  // only memory alterable modes; pc-relative and immediate share mode 111 and are refused
  assign rot_legal = ((ea_mode >= EA_IND) && (ea_mode <= EA_IDX)) ||
                     ((ea_mode == EA_EXT) && (ea_reg <= EA_ABS_LONG));

  // frame size by format code, zero marks an undefined format
  always_comb begin
    fmt = rd_data[FMT_LSB +: 4];
    case (fmt)
      FMT_SHORT: frame_words = WORDS_SHORT;
      FMT_THROW: frame_words = WORDS_SHORT;
      FMT_INSN_ERR: frame_words = WORDS_INSN_ERR;
      FMT_COPROC: frame_words = WORDS_COPROC;
      FMT_MID_SHORT: frame_words = WORDS_MID_SHORT;
      FMT_MID_LONG: frame_words = WORDS_MID_LONG;
      default: frame_words = 6'h00;
    endcase
  end
  assign frame_bytes = {25'h0, frame_words, 1'b0};
  assign disp_sext = {{16{disp[15]}}, disp};

  // predecrement by one byte, but the stack pointer keeps word alignment
  assign ax_dec = rf_rd_x - ((rf_idx_x == SP_INDEX) ? STEP_SP_BYTE : STEP_BYTE);
  assign ay_dec = ((rf_idx_x == rf_idx_y) ? ax_dec : rf_rd_y) -
                  ((rf_idx_y == SP_INDEX) ? STEP_SP_BYTE : STEP_BYTE);

  rbsx_bcd_sub u_bcd (
    .dst(dst_b),
    .src(src_b),
    .x_in(status_in[CC_X]),
    .result(bcd_res),
    .borrow(bcd_borrow)
  );

  // sequencer: one memory access at a time; the memory decimal subtract writes each pointer as its byte is fetched
  always_ff @(posedge clock) begin
    if (srst) begin
      state <= ST_IDLE;
      op <= OP_NONE;
      step <= 2'h0;
      busy <= 1'b0;
      done <= 1'b0;
      base <= RST_WORD32;
      disp <= RST_WORD16;
      status_tmp <= RST_WORD16;
      pc_tmp <= RST_WORD32;
      rd_data <= RST_WORD32;
      dst_full <= RST_WORD32;
      ay_addr <= RST_WORD32;
      src_b <= 8'h00;
      dst_b <= 8'h00;
      reg_y <= 3'h0;
      rf_idx_x <= 4'h0;
      rf_idx_y <= 4'h0;
      rf_we <= 1'b0;
      rf_wr_idx <= 4'h0;
      rf_wr_data <= RST_WORD32;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_size <= SZ_BYTE;
      mem_addr <= RST_WORD32;
      mem_wdata <= 8'h00;
      pc_we <= 1'b0;
      pc_out <= RST_WORD32;
      sp_we <= 1'b0;
      sp_out <= RST_WORD32;
      status_we <= 1'b0;
      status_out <= RST_WORD16;
      cond_we <= 1'b0;
      cond_out <= 5'h00;
      stack_switch <= 1'b0;
      priv_violation <= 1'b0;
      format_error <= 1'b0;
      illegal_ea <= 1'b0;
      resume_frame <= 1'b0;
      rot_start <= 1'b0;
      rot_left <= 1'b0;
      rot_ea_mode <= 3'h0;
      rot_ea_reg <= 3'h0;
    end else begin
      // strobes are single-cycle pulses
      done <= 1'b0;
      rf_we <= 1'b0;
      pc_we <= 1'b0;
      sp_we <= 1'b0;
      status_we <= 1'b0;
      cond_we <= 1'b0;
      stack_switch <= 1'b0;
      priv_violation <= 1'b0;
      format_error <= 1'b0;
      illegal_ea <= 1'b0;
      resume_frame <= 1'b0;
      rot_start <= 1'b0;
      case (state)
        ST_IDLE: begin
          step <= 2'h0;
          base <= sp_in;
          disp <= ext_word;
          mem_we <= 1'b0;
          mem_addr <= sp_in;
          if (accept && rot_hit) begin
            // rotate itself is done by the shifter; hand over direction and operand
            rot_start <= rot_legal;
            illegal_ea <= !rot_legal;
            rot_left <= insn_word[ROT_DIR_BIT];
            rot_ea_mode <= ea_mode;
            rot_ea_reg <= ea_reg;
            done <= 1'b1;
          end else if (accept && (insn_word == OPC_RET_EXCEPT)) begin
            if (!status_in[STATUS_SUPER_BIT]) begin
              priv_violation <= 1'b1;
              done <= 1'b1;
            end else begin
              op <= OP_EXCEPT;
              mem_size <= SZ_WORD;
              mem_req <= 1'b1;
              busy <= 1'b1;
              state <= ST_MEM;
            end
          end else if (accept && (insn_word == OPC_RET_DEALLOC || insn_word == OPC_RET_PLAIN)) begin
            op <= (insn_word == OPC_RET_DEALLOC) ? OP_DEALLOC : OP_RTS;
            mem_size <= SZ_LONG;
            mem_req <= 1'b1;
            busy <= 1'b1;
            state <= ST_MEM;
          end else if (accept && (insn_word == OPC_RET_CODES)) begin
            op <= OP_CODES;
            mem_size <= SZ_WORD;
            mem_req <= 1'b1;
            busy <= 1'b1;
            state <= ST_MEM;
          end else if (accept && bcd_hit) begin
            op <= insn_word[BCD_MODE_BIT] ? OP_BCD_MEM : OP_BCD_REG;
            rf_idx_x <= {insn_word[BCD_MODE_BIT], insn_word[BCD_SRC_LSB +: 3]};
            rf_idx_y <= {insn_word[BCD_MODE_BIT], insn_word[BCD_DST_LSB +: 3]};
            reg_y <= insn_word[BCD_DST_LSB +: 3];
            busy <= 1'b1;
            state <= ST_REG;
          end
        end
        ST_REG: begin
          if (op == OP_BCD_REG) begin
            src_b <= rf_rd_x[7:0];
            dst_b <= rf_rd_y[7:0];
            dst_full <= rf_rd_y;
            state <= ST_CALC;
          end else begin
            // source pointer is stepped back and the source byte fetched from the new address in the same cycle
            rf_we <= 1'b1;
            rf_wr_idx <= rf_idx_x;
            rf_wr_data <= ax_dec;
            ay_addr <= ay_dec;
            mem_addr <= ax_dec;
            mem_size <= SZ_BYTE;
            mem_req <= 1'b1;
            state <= ST_MEM;
          end
        end
        ST_MEM: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            rd_data <= mem_rdata;
            state <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          state <= ST_MEM;
          step <= step + 2'h1;
          mem_we <= 1'b0;
          case (op)
            OP_RTS: begin
              pc_we <= 1'b1;
              pc_out <= rd_data;
              sp_we <= 1'b1;
              sp_out <= base + OFS_LONG;
              busy <= 1'b0;
              done <= 1'b1;
              state <= ST_IDLE;
            end
            OP_DEALLOC: begin
              pc_we <= 1'b1;
              pc_out <= rd_data;
              sp_we <= 1'b1;
              sp_out <= base + OFS_LONG + disp_sext;
              busy <= 1'b0;
              done <= 1'b1;
              state <= ST_IDLE;
            end
            OP_CODES: begin
              if (step == 2'h0) begin
                status_tmp <= rd_data[15:0];
                mem_addr <= base + OFS_WORD;
                mem_size <= SZ_LONG;
                mem_req <= 1'b1;
              end else begin
                // only the low five condition bits land; the supervisor part is never written
                cond_we <= 1'b1;
                cond_out <= status_tmp[4:0];
                pc_we <= 1'b1;
                pc_out <= rd_data;
                sp_we <= 1'b1;
                sp_out <= base + OFS_WORD + OFS_LONG;
                busy <= 1'b0;
                done <= 1'b1;
                state <= ST_IDLE;
              end
            end
            OP_EXCEPT: begin
              if (step == 2'h0) begin
                status_tmp <= rd_data[15:0];
                mem_addr <= base + OFS_WORD;
                mem_size <= SZ_LONG;
                mem_req <= 1'b1;
              end else if (step == 2'h1) begin
                pc_tmp <= rd_data;
                mem_addr <= base + OFS_FMT;
                mem_size <= SZ_WORD;
                mem_req <= 1'b1;
              end else if (frame_words == 6'h00) begin
                // nothing restored, so the handler sees the frame intact
                format_error <= 1'b1;
                busy <= 1'b0;
                done <= 1'b1;
                state <= ST_IDLE;
              end else begin
                status_we <= 1'b1;
                status_out <= status_tmp;
                sp_we <= 1'b1;
                sp_out <= base + frame_bytes;
                if (fmt == FMT_THROW) begin
                  stack_switch <= 1'b1;
                  state <= ST_SWITCH;
                end else begin
                  pc_we <= 1'b1;
                  pc_out <= pc_tmp;
                  resume_frame <= fmt[3];
                  busy <= 1'b0;
                  done <= 1'b1;
                  state <= ST_IDLE;
                end
              end
            end
            default: begin
              if (step == 2'h0) begin
                src_b <= rd_data[7:0];
                rf_we <= 1'b1;
                rf_wr_idx <= rf_idx_y;
                rf_wr_data <= ay_addr;
                mem_addr <= ay_addr;
                mem_size <= SZ_BYTE;
                mem_req <= 1'b1;
              end else if (step == 2'h1) begin
                dst_b <= rd_data[7:0];
                state <= ST_CALC;
              end else begin
                busy <= 1'b0;
                done <= 1'b1;
                state <= ST_IDLE;
              end
            end
          endcase
        end
        ST_CALC: begin
          // n and v are left as they were; zero only ever clears
          cond_we <= 1'b1;
          cond_out <= {bcd_borrow, status_in[CC_N], status_in[CC_Z] & (bcd_res == 8'h00),
                       status_in[CC_V], bcd_borrow};
          if (op == OP_BCD_REG) begin
            rf_we <= 1'b1;
            rf_wr_idx <= {1'b0, reg_y};
            rf_wr_data <= {dst_full[31:8], bcd_res};
            busy <= 1'b0;
            done <= 1'b1;
            state <= ST_IDLE;
          end else begin
            mem_we <= 1'b1;
            mem_wdata <= bcd_res;
            mem_req <= 1'b1;
            step <= 2'h2;
            state <= ST_MEM;
          end
        end
        ST_SWITCH: begin
          // let the datapath apply the new stack before it is sampled
          state <= ST_RESTART;
        end
        default: begin
          base <= sp_in;
          mem_addr <= sp_in;
          mem_size <= SZ_WORD;
          mem_req <= 1'b1;
          step <= 2'h0;
          state <= ST_MEM;
        end
      endcase
    end
  end

  // checks on the externally visible behaviour
  sequence take_except_user;
    accept && insn_word == OPC_RET_EXCEPT && !status_in[STATUS_SUPER_BIT];
  endsequence
  sequence take_rot;
    accept && rot_hit;
  endsequence

  rot_dir_a: assert property (@(posedge clock) disable iff (srst)
    take_rot |=> rot_left == $past(insn_word[ROT_DIR_BIT]))
    else $error("rotate direction does not follow the direction bit");
  rot_mode_a: assert property (@(posedge clock) disable iff (srst)
    take_rot |=> (rot_start != illegal_ea) && (illegal_ea ==
      ($past(ea_mode) < EA_IND || ($past(ea_mode) == EA_EXT && $past(ea_reg) > EA_ABS_LONG))))
    else $error("rotate operand mode check wrong");
  dealloc_sp_a: assert property (@(posedge clock) disable iff (srst)
    (sp_we && op == OP_DEALLOC) |-> pc_we && sp_out == base + 32'h4 + {{16{disp[15]}}, disp})
    else $error("deallocate return stack pointer wrong");
  except_user_a: assert property (@(posedge clock) disable iff (srst)
    take_except_user |=> priv_violation && !mem_req && !sp_we && !status_we ##1 !busy)
    else $error("user return from exception not trapped");
  except_order_a: assert property (@(posedge clock) disable iff (srst)
    (mem_req && op == OP_EXCEPT && state == ST_MEM && step == 2'h1) |->
      mem_size == SZ_LONG && mem_addr == base + 32'h2)
    else $error("return from exception pc pop misplaced");
  except_frame_a: assert property (@(posedge clock) disable iff (srst)
    (sp_we && op == OP_EXCEPT) |-> (sp_out - base) inside {32'd8, 32'd12, 32'd20, 32'd32, 32'd92})
    else $error("frame size removed is wrong");
  fmt_err_a: assert property (@(posedge clock) disable iff (srst)
    format_error |-> !pc_we && !status_we && !sp_we && done && $past(frame_words) == 6'h00)
    else $error("format error with state update");
  throw_sw_a: assert property (@(posedge clock) disable iff (srst)
    stack_switch |-> !pc_we ##2 (mem_req && mem_addr == $past(sp_in) && mem_size == SZ_WORD))
    else $error("throwaway frame did not continue on new stack");
  codes_ret_a: assert property (@(posedge clock) disable iff (srst)
    (cond_we && op == OP_CODES) |-> !status_we && pc_we && sp_out == base + 32'h6)
    else $error("restore codes return wrong");
  rts_plain_a: assert property (@(posedge clock) disable iff (srst)
    (pc_we && op == OP_RTS) |-> !cond_we && sp_we && sp_out == base + 32'h4)
    else $error("plain return wrong");
  bcd_flag_a: assert property (@(posedge clock) disable iff (srst)
    (cond_we && (op == OP_BCD_REG || op == OP_BCD_MEM)) |->
      cond_out[CC_X] == cond_out[CC_C] && (!cond_out[CC_Z] || $past(status_in[CC_Z])))
    else $error("decimal subtract flags wrong");
  bcd_byte_a: assert property (@(posedge clock) disable iff (srst)
    (mem_req && op == OP_BCD_MEM) |-> mem_size == SZ_BYTE)
    else $error("decimal subtract memory access not byte");
endmodule : rbsx_exec

// ===== logic/rbsx_pkg.sv
// rbsx_pkg: constants and types shared by the return and decimal-subtract executor.
// assumes a 16-bit opcode stream, 32-bit stack pointer and an external datapath.
package rbsx_pkg;
  // fixed return opcodes
  localparam logic [15:0] OPC_RET_DEALLOC = 16'h4e74;
  localparam logic [15:0] OPC_RET_EXCEPT = 16'h4e73;
  localparam logic [15:0] OPC_RET_CODES = 16'h4e77;
  localparam logic [15:0] OPC_RET_PLAIN = 16'h4e75;
  // pattern and mask for the memory extend-rotate and the decimal subtract
  localparam logic [15:0] ROT_MEM_MASK = 16'hfec0;
  localparam logic [15:0] ROT_MEM_CODE = 16'he4c0;
  localparam logic [15:0] BCD_SUB_MASK = 16'hf1f0;
  localparam logic [15:0] BCD_SUB_CODE = 16'h8100;
  // field positions
  localparam int ROT_DIR_BIT = 8;
  localparam int EA_MODE_LSB = 3;
  localparam int EA_REG_LSB = 0;
  localparam int BCD_DST_LSB = 9;
  localparam int BCD_MODE_BIT = 3;
  localparam int BCD_SRC_LSB = 0;
  localparam int STATUS_SUPER_BIT = 13;
  localparam int FMT_LSB = 12;
  // condition code bit positions
  localparam int CC_X = 4;
  localparam int CC_N = 3;
  localparam int CC_Z = 2;
  localparam int CC_V = 1;
  localparam int CC_C = 0;
  // effective address modes
  localparam logic [2:0] EA_IND = 3'h2;
  localparam logic [2:0] EA_IDX = 3'h6;
  localparam logic [2:0] EA_EXT = 3'h7;
  localparam logic [2:0] EA_ABS_LONG = 3'h1;
  // exception frame format codes
  localparam logic [3:0] FMT_SHORT = 4'h0;
  localparam logic [3:0] FMT_THROW = 4'h1;
  localparam logic [3:0] FMT_INSN_ERR = 4'h2;
  localparam logic [3:0] FMT_COPROC = 4'h9;
  localparam logic [3:0] FMT_MID_SHORT = 4'ha;
  localparam logic [3:0] FMT_MID_LONG = 4'hb;
  // words removed per format
  localparam logic [5:0] WORDS_SHORT = 6'h04;
  localparam logic [5:0] WORDS_INSN_ERR = 6'h06;
  localparam logic [5:0] WORDS_COPROC = 6'h0a;
  localparam logic [5:0] WORDS_MID_SHORT = 6'h10;
  localparam logic [5:0] WORDS_MID_LONG = 6'h2e;
  // stack offsets in bytes
  localparam logic [31:0] OFS_WORD = 32'h0000_0002;
  localparam logic [31:0] OFS_LONG = 32'h0000_0004;
  localparam logic [31:0] OFS_FMT = 32'h0000_0006;
  localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
  localparam logic [31:0] STEP_SP_BYTE = 32'h0000_0002;
  // register file index of the stack pointer (address registers are 8..15)
  localparam logic [3:0] SP_INDEX = 4'hf;
  localparam logic [2:0] SP_REG = 3'h7;
  // memory access sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  // reset values
  localparam logic [31:0] RST_WORD32 = 32'h0000_0000;
  localparam logic [15:0] RST_WORD16 = 16'h0000;
  typedef enum logic [2:0] {
    OP_NONE, OP_DEALLOC, OP_EXCEPT, OP_CODES, OP_RTS, OP_BCD_REG, OP_BCD_MEM
  } rbsx_op_e;
endpackage : rbsx_pkg

// ===== verif/rbsx_tb.sv
// testbench for rbsx_exec: returns, frame formats, memory rotate decode, decimal subtract.
// assumes the block's flop-timed strobes; the bench answers memory and register reads itself.
`timescale 1ns/100ps
module testbench;
  import rbsx_pkg::*;
  logic clock = 0, srst = 1, insn_valid = 0, mem_ack = 0, lg;
  logic [15:0] insn_word = 0, ext_word = 0, status_in = 0, csr, mw [logic [31:0]];
  logic [31:0] sp_in = 0, mem_rdata = 0, cp, cs, cr, cw, rf_rd_x, rf_rd_y, rf [16];
  logic busy, done, rf_we, mem_req, mem_we, pc_we, sp_we, status_we, cond_we, stack_switch;
  logic priv_violation, format_error, illegal_ea, resume_frame, rot_start, rot_left;
  logic [3:0] rf_idx_x, rf_idx_y, rf_wr_idx, ci;
  logic [1:0] mem_size;
  logic [2:0] rot_ea_mode, rot_ea_reg;
  logic [7:0] mem_wdata;
  logic [31:0] rf_wr_data, mem_addr, pc_out, sp_out;
  logic [15:0] status_out;
  logic [4:0] cond_out, cc_seen;
  logic [10:0] ev = '0;
  logic [5:0] e;
  logic [3:0] fmts [8] = '{4'h0, 4'h2, 4'h9, 4'ha, 4'hb, 4'h8, 4'h3, 4'h1};
  int wrds [5] = '{4, 6, 10, 16, 46};
  logic [7:0] bd [4] = '{8'h42, 8'h15, 8'h00, 8'h00};
  logic [7:0] bs [4] = '{8'h15, 8'h42, 8'h00, 8'h01};
  logic [7:0] br [4] = '{8'h27, 8'h72, 8'h00, 8'h99};
  logic [1:0] xb [4] = '{2'b00, 2'b11, 2'b00, 2'b01}; // extend in, borrow out
  int n_errors = 0, checks = 0, cyc = 0;

  rbsx_exec dut_u (.clock, .srst, .insn_valid, .insn_word, .ext_word, .status_in, .sp_in,
    .rf_rd_x, .rf_rd_y, .mem_ack, .mem_rdata, .busy, .done, .rf_idx_x, .rf_idx_y, .rf_we,
    .rf_wr_idx, .rf_wr_data, .mem_req, .mem_we, .mem_size, .mem_addr, .mem_wdata, .pc_we,
    .pc_out, .sp_we, .sp_out, .status_we, .status_out, .cond_we, .cond_out, .stack_switch,
    .priv_violation, .format_error, .illegal_ea, .resume_frame, .rot_start, .rot_left,
    .rot_ea_mode, .rot_ea_reg);

  initial forever #2.5 clock = ~clock;
  // register file answers combinationally, so it is ready in the cycle after the index is decoded
  assign rf_rd_x = rf[rf_idx_x];
  assign rf_rd_y = rf[rf_idx_y];

  // memory answers one cycle after each request; strobes are collected per instruction
  always @(posedge clock) begin
    cyc <= cyc + 1;
    mem_ack <= mem_req && !mem_ack;
    if (mem_req) mem_rdata <= (mem_size == SZ_LONG) ? {mw[mem_addr], mw[mem_addr + 2]} :
      {16'h0, mw[mem_addr]};
    ev <= ev | {rf_we, rot_start, illegal_ea, resume_frame, format_error, priv_violation,
      stack_switch, cond_we, status_we, sp_we, pc_we};
    if (pc_we) cp <= pc_out;
    if (sp_we) cs <= sp_out;
    if (status_we) csr <= status_out;
    if (cond_we) cc_seen <= cond_out;
    if (rf_we) cr <= rf_wr_data;
    if (rf_we) ci <= rf_wr_idx;
    if (mem_we) cw <= {mem_addr[23:0], mem_wdata};
    if (stack_switch) sp_in <= 32'h0000_4000; // datapath moves to the system stack
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  // one instruction; returns once done has been seen and captures have landed
  task automatic exec(input logic [15:0] op, ext, stat, input logic [31:0] sp);
    @(negedge clock) ev <= '0;
    @(posedge clock);
    insn_valid <= 1'b1;
    insn_word <= op;
    ext_word <= ext;
    status_in <= stat;
    sp_in <= sp;
    @(posedge clock);
    insn_valid <= 1'b0;
    repeat (200) if (done !== 1'b1) @(posedge clock);
    // a missing done pulse is a mismatch of its own
    if (done !== 1'b1) n_errors++;
    #1;
  endtask : exec

  task automatic wrap_up;
    $display("errors %0d, checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  initial begin
    for (int i = 0; i < 16; i++) rf[i] = 32'ha5a5_a500 + 32'(i);
    mw[32'h1000] = 16'h0000;
    mw[32'h1002] = 16'h2468;
    mw[32'h2000] = 16'h0015;
    mw[32'h2002] = 16'h0000;
    mw[32'h2004] = 16'h3000;
    mw[32'h4000] = 16'h2004;
    mw[32'h4002] = 16'h0000;
    mw[32'h4004] = 16'h5000;
    mw[32'h4006] = 16'h0000;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    // plain return, then deallocate with negative and positive displacement
    exec(OPC_RET_PLAIN, 16'h0, 16'h2700, 32'h1000);
    check(32'(ev), 32'h003);
    check(cp, 32'h2468);
    check(cs, 32'h1004);
    exec(OPC_RET_DEALLOC, 16'hfff0, 16'h2700, 32'h1000);
    check(cs, 32'h0ff4);
    check(cp, 32'h2468);
    exec(OPC_RET_DEALLOC, 16'h0010, 16'h0000, 32'h1000);
    check(cs, 32'h1014);
    // restore codes leaves the status word alone
    exec(OPC_RET_CODES, 16'h0, 16'h2700, 32'h2000);
    check(32'(ev), 32'h00b);
    check({cp[15:0], 11'h0, cc_seen}, 32'h3000_0015);
    check(cs, 32'h2006);
    // user state traps without touching the stack
    exec(OPC_RET_EXCEPT, 16'h0, 16'h0000, 32'h2000);
    check(32'(ev), 32'h020);
    // all six defined frame formats and two undefined ones; the last one switches stacks
    for (int i = 0; i < 8; i++) begin
      mw[32'h2006] = {fmts[i], 12'h000};
      exec(OPC_RET_EXCEPT, 16'h0, 16'h2700, 32'h2000);
      if (i < 5) begin
        check(32'(ev), i > 1 ? 32'h087 : 32'h007);
        check(cs, 32'(32'h2000 + 2 * wrds[i]));
        check({cp[15:0], csr}, 32'h3000_0015);
      end else if (i < 7) begin
        check(32'(ev), 32'h040);
      end else begin
        check(32'(ev), 32'h017);
        check({cp[15:0], csr, cs}, {16'h5000, 16'h2004, 32'h4008});
      end
    end
    // memory rotate over all mode and register codes, direction alternating
    for (int k = 0; k < 64; k++) begin
      e = 6'(k);
      lg = (e[5:3] >= 3'h2 && e[5:3] <= 3'h6) || (e[5:3] == 3'h7 && e[2:0] < 3'h2);
      exec(ROT_MEM_CODE | {7'h0, e[0] ^ e[3], 2'h0, e}, 16'h0, 16'h2700, 32'h1000);
      check(32'(ev), lg ? 32'h200 : 32'h100);
      if (lg) check(32'({rot_left, rot_ea_mode, rot_ea_reg}), 32'({e[0] ^ e[3], e}));
    end
    // register decimal subtract: borrow, extend in, zero kept, wrap to 99
    for (int j = 0; j < 4; j++) begin
      rf[j][7:0] = bd[j];
      rf[7 - j][7:0] = bs[j];
      exec(BCD_SUB_CODE | 16'(j << 9) | 16'(7 - j), 16'h0, 16'h2704 | {11'h0, xb[j][1], 4'h0},
        32'h1000);
      check(32'(ev), 32'h408);
      check(cr, {rf[j][31:8], br[j]});
      check(32'(ci), 32'(j));
      check(32'(cc_seen), 32'({xb[j][0], 1'b0, br[j] == 8'h00, 1'b0, xb[j][0]}));
    end
    // memory decimal subtract: both pointers step back a byte, result lands at the second
    rf[9] = 32'h0000_3001;
    rf[10] = 32'h0000_3011;
    mw[32'h3000] = 16'h0015;
    mw[32'h3010] = 16'h0042;
    exec(BCD_SUB_CODE | 16'h0409, 16'h0, 16'h2704, 32'h1000);
    check(32'(ev), 32'h408);
    check(cw, 32'h0030_1027);
    check({cr[15:0], 12'h0, ci}, 32'h3010_000a);
    check(32'(cc_seen), 32'h0);
    check(32'(busy), 32'h0);
    wrap_up();
  end
endmodule : testbench
